/* File: lsd_cfg.svh */
// Purpose: constants of the LED driver serial slave link
// Assumes: 8-bit registers behind a 2-bit register pointer
// Notes:   offsets, field positions, reset values and the device address only
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LSD_OFS_FIRST_MODE 2'h0
`define LSD_OFS_MODE2 2'h1
`define LSD_OFS_LED_LO 2'h2
`define LSD_OFS_LED_HI 2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LSD_FIRST_MODE_HALT_BIT 4
`define LSD_MODE2_PUSH_PULL_BIT 2

// ----------------------------------------
// Reset values and the fixed device address
// ----------------------------------------
`define LSD_RST_FIRST_MODE 8'h00
`define LSD_RST_MODE2 8'h04
`define LSD_RST_LED 8'h00
`define LSD_RST_ADDR 7'h15

`endif

/* File: lsd_pkg.sv */
// Purpose: shared types of the LED driver serial slave link
// Assumes: nothing beyond the cfg header
// Notes:   states of the byte engine
package lsd_pkg;

  typedef enum logic [2:0] {
    LSD_IDLE,
    LSD_ADDR,
    LSD_ACK_ADDR,
    LSD_WRITE,
    LSD_ACK_WRITE,
    LSD_READ,
    LSD_READ_ACK
  } lsd_state_e;

  typedef logic [7:0] lsd_byte_t;

endpackage

/* File: lsd_bus_cond.sv */
// Purpose: synchronise the bus pins and find clock edges, START and STOP
// Assumes: ref_clk_in much faster than the bus clock
// Notes:   the first flop of each synchroniser feeds only the second
`timescale 1ns/10ps

module lsd_bus_cond (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_s_out,
  output logic sda_s_out,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);

  logic scl_m;
  logic sda_m;
  logic scl_q;
  logic sda_q;
  logic scl_p;
  logic sda_p;

  // ----------------------------------------
  // Two-flop synchronisers plus one history stage
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      scl_m <= 1'h1;
      sda_m <= 1'h1;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      scl_p <= 1'h1;
      sda_p <= 1'h1;
    end else begin
      scl_m <= scl_in;
      sda_m <= sda_in;
      scl_q <= scl_m;
      sda_q <= sda_m;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  assign scl_s_out = scl_q;
  assign sda_s_out = sda_q;
  assign scl_rise_out = scl_q & ~scl_p;
  assign scl_fall_out = ~scl_q & scl_p;
  // Data edge while the clock stays high is a framing condition
  assign start_out = scl_q & scl_p & sda_p & ~sda_q;
  assign stop_out = scl_q & scl_p & ~sda_p & sda_q;

endmodule

/* File: lsd_slave_link.sv */
// Purpose: two-wire slave link of a multi-channel LED driver
// Assumes: bus pins are asynchronous to ref_clk_in and are synchronised
// Notes:   four byte registers, auto-incrementing pointer
`timescale 1ns/10ps
`include "lsd_cfg.svh"

module lsd_slave_link (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic [15:0] led_out,
  output logic [15:0] led_oe_n_out,
  output logic oscillator_running_out,
  output logic busy_out
);

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  lsd_bus_cond u_cond (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_s_out(scl_s),
    .sda_s_out(sda_s),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start_ev),
    .stop_out(stop_ev)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  lsd_pkg::lsd_state_e state;
  lsd_pkg::lsd_byte_t shift;
  lsd_pkg::lsd_byte_t tx;
  lsd_pkg::lsd_byte_t regs [0:3];
  logic [2:0] cnt;
  logic byte_done;
  logic pull_low;
  logic read_mode;
  logic ptr_loaded;
  logic [1:0] ptr;
  logic [15:0] led_state;

  function automatic logic [1:0] lsd_next_ptr(input logic [1:0] p);
    lsd_next_ptr = p + 2'h1;
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire addr_match = (shift[7:1] == `LSD_RST_ADDR);
  wire [7:0] rd_byte = regs[ptr];
  wire oscillator_run = ~regs[`LSD_OFS_FIRST_MODE][`LSD_FIRST_MODE_HALT_BIT];
  wire push_pull = regs[`LSD_OFS_MODE2][`LSD_MODE2_PUSH_PULL_BIT];
  wire [15:0] led_req = {regs[`LSD_OFS_LED_HI], regs[`LSD_OFS_LED_LO]};
  wire store_byte = (state == lsd_pkg::LSD_WRITE) && scl_fall && byte_done && ptr_loaded;
  wire [1:0] next_ptr = lsd_next_ptr(ptr);

  // SDA is driven open-drain: the enable is low only while pulling low
  assign sda_out = 1'h0;
  assign sda_oe_n_out = ~pull_low;

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      state <= lsd_pkg::LSD_IDLE;
      shift <= 8'h00;
      tx <= 8'h00;
      cnt <= 3'h0;
      byte_done <= 1'h0;
      pull_low <= 1'h0;
      read_mode <= 1'h0;
      ptr_loaded <= 1'h0;
      ptr <= 2'h0;
    end else if (start_ev) begin
      // Any partial byte is dropped and an address byte is awaited
      state <= lsd_pkg::LSD_ADDR;
      cnt <= 3'h0;
      byte_done <= 1'h0;
      pull_low <= 1'h0;
      ptr_loaded <= 1'h0;
    end else if (stop_ev) begin
      state <= lsd_pkg::LSD_IDLE;
      cnt <= 3'h0;
      byte_done <= 1'h0;
      pull_low <= 1'h0;
    end else begin
      case (state)
        lsd_pkg::LSD_ADDR, lsd_pkg::LSD_WRITE: begin
          // Data is taken at the rising clock edge, stable while high
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            cnt <= cnt + 3'h1;
            byte_done <= (cnt == 3'h7);
          end else if (scl_fall && byte_done) begin
            byte_done <= 1'h0;
            if (state == lsd_pkg::LSD_ADDR) begin
              if (addr_match) begin
                pull_low <= 1'h1;
                read_mode <= shift[0];
                state <= lsd_pkg::LSD_ACK_ADDR;
              end else begin
                // Not ours: stay off the bus until the next START
                state <= lsd_pkg::LSD_IDLE;
              end
            end else begin
              pull_low <= 1'h1;
              state <= lsd_pkg::LSD_ACK_WRITE;
              if (!ptr_loaded) begin
                ptr <= shift[1:0];
                ptr_loaded <= 1'h1;
              end else begin
                ptr <= next_ptr;
              end
            end
          end
        end
        lsd_pkg::LSD_ACK_ADDR: begin
          // Low is held across the whole high phase of the slot
          if (scl_fall) begin
            if (read_mode) begin
              pull_low <= ~rd_byte[7];
              tx <= {rd_byte[6:0], 1'h0};
              ptr <= next_ptr;
              cnt <= 3'h1;
              state <= lsd_pkg::LSD_READ;
            end else begin
              pull_low <= 1'h0;
              cnt <= 3'h0;
              state <= lsd_pkg::LSD_WRITE;
            end
          end
        end
        lsd_pkg::LSD_ACK_WRITE: begin
          if (scl_fall) begin
            pull_low <= 1'h0;
            cnt <= 3'h0;
            state <= lsd_pkg::LSD_WRITE;
          end
        end
        lsd_pkg::LSD_READ: begin
          if (scl_fall) begin
            if (cnt == 3'h0) begin
              // Transmitter releases the line for the acknowledge slot
              pull_low <= 1'h0;
              state <= lsd_pkg::LSD_READ_ACK;
            end else begin
              pull_low <= ~tx[7];
              tx <= {tx[6:0], 1'h0};
              cnt <= cnt + 3'h1;
            end
          end
        end
        lsd_pkg::LSD_READ_ACK: begin
          if (scl_rise) begin
            byte_done <= ~sda_s;
            if (sda_s) begin
              // End of read: line stays released for the master's STOP
              state <= lsd_pkg::LSD_IDLE;
            end
          end else if (scl_fall && byte_done) begin
            byte_done <= 1'h0;
            pull_low <= ~rd_byte[7];
            tx <= {rd_byte[6:0], 1'h0};
            ptr <= next_ptr;
            cnt <= 3'h1;
            state <= lsd_pkg::LSD_READ;
          end
        end
        default: begin
          // Idle waits for a START on a free bus
          pull_low <= 1'h0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      regs[`LSD_OFS_FIRST_MODE] <= `LSD_RST_FIRST_MODE;
      regs[`LSD_OFS_MODE2] <= `LSD_RST_MODE2;
      regs[`LSD_OFS_LED_LO] <= `LSD_RST_LED;
      regs[`LSD_OFS_LED_HI] <= `LSD_RST_LED;
    end else if (store_byte) begin
      regs[ptr] <= shift;
    end
  end

  // ----------------------------------------
  // LED outputs
  // ----------------------------------------
  // A halted oscillator freezes the LED pattern; LED register writes still land
  // in the registers and take effect once it runs again, MODE2 writes at once.
  logic [15:0] next_led_state;
  logic [15:0] next_led_out;
  logic [15:0] next_led_oe_n;

  assign next_led_state = oscillator_run ? led_req : led_state;
  assign next_led_out = push_pull ? ~next_led_state : 16'h0000;
  assign next_led_oe_n = push_pull ? 16'h0000 : ~next_led_state;

  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      // Push-pull, driving high, everything off
      led_state <= 16'h0000;
      led_out <= 16'hffff;
      led_oe_n_out <= 16'h0000;
      oscillator_running_out <= 1'h1;
      busy_out <= 1'h0;
    end else begin
      led_state <= next_led_state;
      led_out <= next_led_out;
      led_oe_n_out <= next_led_oe_n;
      // Status pins are registered so they never glitch on decode
      oscillator_running_out <= oscillator_run;
      busy_out <= (state != lsd_pkg::LSD_IDLE);
    end
  end

endmodule

/* File: lsd_slave_link_props.sv */
// Purpose: port checks of the slave link
// Assumes: bus pins oversampled by ref_clk_in
// Notes: bound from the bench top
`timescale 1ns/10ps
module lsd_slave_link_props (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic [15:0] led_out,
  input wire logic [15:0] led_oe_n_out,
  input wire logic oscillator_running_out,
  input wire logic busy_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_rst;
    $rose(reset_n_in) |-> sda_oe_n_out && led_out == 16'hffff && led_oe_n_out == 16'h0
      && oscillator_running_out && !busy_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  // Device drive may only move a few cycles after SCL fell
  property p_drv;
    $changed(sda_oe_n_out) |-> !scl_in && !$past(scl_in, 2)
      && ($past(scl_in, 3) || $past(scl_in, 4) || $past(scl_in, 5) || $past(scl_in, 6));
  endproperty
  a_drv: assert property (p_drv) else $error("sda moved off scl low");
  property p_hold; $rose(scl_in) && !sda_oe_n_out |=> (!sda_oe_n_out) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("low not held");
  property p_zero; sda_out == 1'h0; endproperty
  a_zero: assert property (p_zero) else $error("sda value not low");
  property p_start; scl_in && $fell(sda_in) |-> ##[1:8] busy_out; endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop; scl_in && $rose(sda_in) |-> ##[1:8] !busy_out; endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_halt;
    (!oscillator_running_out) [*3] |-> $stable(led_out) && $stable(led_oe_n_out);
  endproperty
  a_halt: assert property (p_halt) else $error("pins moved while halted");
  property p_od; led_oe_n_out != 16'h0 |-> led_out == 16'h0; endproperty
  a_od: assert property (p_od) else $error("open drain value high");
  c_ack: cover property ($fell(sda_oe_n_out));
  c_halt: cover property (!oscillator_running_out);
  c_od: cover property (led_oe_n_out != 16'h0);
endmodule

/* File: lsd_master_model.sv */
// Purpose: bus master model for the slave link
// Assumes: SCL high follows link_clk_in high
// Notes: open drain, oe_n low pulls the wire
`timescale 1ns/10ps
module lsd_master_model (
  input wire logic link_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_n_out
);
  logic r;
  initial begin
    scl_out = 1'h1;
    sda_oe_n_out = 1'h1;
  end
  // Data moves 20 ns into SCL low, clear of the device's answer
  task automatic clk_bit(input logic b, output logic s);
    #20 sda_oe_n_out = b;
    @(posedge link_clk_in) scl_out = 1'h1;
    @(negedge link_clk_in) s = sda_in;
    scl_out = 1'h0;
  endtask
  task automatic start;
    #20 sda_oe_n_out = 1'h1;
    @(posedge link_clk_in) scl_out = 1'h1;
    #30 sda_oe_n_out = 1'h0;
    @(negedge link_clk_in) scl_out = 1'h0;
  endtask
  task automatic stop;
    #20 sda_oe_n_out = 1'h0;
    @(posedge link_clk_in) scl_out = 1'h1;
    #30 sda_oe_n_out = 1'h1;
  endtask
  // A short count leaves the byte cut off with no acknowledge slot
  task automatic send(input logic [7:0] d, input int n, output logic ack);
    for (int i = 7; i > 7 - n; i--) clk_bit(d[i], r);
    if (n == 8) clk_bit(1'h1, r);
    ack = !r;
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'h1, b);
      d[i] = b;
    end
    clk_bit(!ack, r);
  endtask
endmodule

/* File: test_lsd_slave_link.sv */
// Purpose: self-checking bench of the slave link
// Assumes: wire pulled up, device address fixed
// Notes: register writes as rows, awkward cases after
`timescale 1ns/10ps
`include "lsd_cfg.svh"
module test_lsd_slave_link;
  typedef struct {logic [7:0] p, d; logic [15:0] led; logic run;} lsd_row_s;
  lsd_row_s rows [6] = '{'{8'h02, 8'h5a, 16'hffa5, 1'h1}, '{8'h03, 8'h81, 16'h7ea5, 1'h1},
    '{8'h00, 8'h10, 16'h7ea5, 1'h0}, '{8'h02, 8'hff, 16'h7ea5, 1'h0},
    '{8'h00, 8'h00, 16'h7e00, 1'h1}, '{8'h03, 8'h00, 16'hff00, 1'h1}};
  logic [47:0] burst = 48'h020ff000043c;
  logic [23:0] rx = 24'h3cf000;
  logic ref_clk_in = 1'h0;
  logic link_clk = 1'h0;
  logic reset_n_in = 1'h0;
  logic scl_in, m_oe_n, sda_out, sda_oe_n_out, oscillator_running_out, busy_out, ak;
  logic [15:0] led_out, led_oe_n_out;
  logic [7:0] rd;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire logic sda_in = m_oe_n & (sda_oe_n_out !== 1'h0);
  initial forever #2.5 ref_clk_in = !ref_clk_in;
  initial begin
    #7.3;
    forever #62.5 link_clk = !link_clk;
  end
  lsd_slave_link DUT (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out),
    .led_out(led_out),
    .led_oe_n_out(led_oe_n_out),
    .oscillator_running_out(oscillator_running_out),
    .busy_out(busy_out)
  );
  lsd_master_model m (.link_clk_in(link_clk), .sda_in(sda_in), .scl_out(scl_in),
    .sda_oe_n_out(m_oe_n));
  task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic settle;
    repeat (12) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic open_w;
    m.start();
    m.send({`LSD_RST_ADDR, 1'h0}, 8, ak);
    check("addr ack", ak, 16'h1);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    open_w();
    m.send(p, 8, ak);
    check("ptr ack", ak, 16'h1);
    m.send(d, 8, ak);
    check("data ack", ak, 16'h1);
    m.stop();
    settle();
  endtask
  task automatic summarize;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      summarize();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'h1;
    repeat (4) @(posedge ref_clk_in);
    foreach (rows[i]) begin
      wr(rows[i].p, rows[i].d);
      check("led", led_out, rows[i].led);
      check("oscillator", oscillator_running_out, rows[i].run);
    end
    // A cut byte and a fresh START must leave the address aligned
    m.start();
    m.send(8'h2a, 4, ak);
    m.start();
    m.send({`LSD_RST_ADDR, 1'h0}, 8, ak);
    check("restart ack", ak, 16'h1);
    m.stop();
    settle();
    check("busy", busy_out, 16'h0);
    // Six bytes in one frame wrap the pointer
    open_w();
    for (int i = 0; i < 6; i++) begin
      m.send(burst[47-8*i -: 8], 8, ak);
      check("burst ack", ak, 16'h1);
    end
    m.stop();
    settle();
    check("led", led_out, 16'h0fc3);
    open_w();
    m.send(8'h02, 8, ak);
    m.start();
    m.send({`LSD_RST_ADDR, 1'h1}, 8, ak);
    for (int i = 0; i < 3; i++) begin
      m.recv(i < 2, rd);
      check("read", rd, rx[23-8*i -: 8]);
    end
    #30;
    check("released", sda_oe_n_out, 16'h1);
    m.stop();
    m.start();
    m.send(8'h28, 8, ak);
    check("foreign ack", ak, 16'h0);
    m.stop();
    wr(8'h01, 8'h00);
    check("od enable", led_oe_n_out, 16'h0fc3);
    // Reset in mid-run must bring back push-pull outputs driving high
    @(posedge ref_clk_in);
    reset_n_in <= 1'h0;
    repeat (3) @(posedge ref_clk_in);
    reset_n_in <= 1'h1;
    @(posedge ref_clk_in);
    #1;
    check("reset led", led_out, 16'hffff);
    check("reset od", led_oe_n_out, 16'h0000);
    check("reset run", oscillator_running_out, 16'h1);
    check("reset busy", busy_out, 16'h0);
    check("reset sda", sda_oe_n_out, 16'h1);
    summarize();
  end
endmodule
bind lsd_slave_link lsd_slave_link_props u_props (
  .ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_n_out(sda_oe_n_out),
  .led_out(led_out),
  .led_oe_n_out(led_oe_n_out),
  .oscillator_running_out(oscillator_running_out),
  .busy_out(busy_out)
);
